//--- rtl/wor_timer_defines.vh
// Constants for the wake-on-radio sleep timer control block.
// Assumes the block is clocked from the crystal oscillator clock.
`ifndef WOR_TIMER_DEFINES_VH
`define WOR_TIMER_DEFINES_VH

// Register offsets on the register port
`define OFS_FIRST_COUNT_HIGH 6'h1E
`define OFS_FIRST_COUNT_LOW  6'h1F
`define OFS_WAKE_CONTROL     6'h20

// Control register field positions
`define BIT_RC_POWERDOWN     7
`define MSB_SECOND_CODE      6
`define LSB_SECOND_CODE      4
`define BIT_RC_CALIB_ENABLE  3
`define BIT_UNUSED_CONTROL   2
`define MSB_RESOLUTION       1
`define LSB_RESOLUTION       0

// Reset values
`define RST_FIRST_COUNT_HIGH 8'h87
`define RST_FIRST_COUNT_LOW  8'h6B
`define RST_RC_POWERDOWN     1'h1
`define RST_SECOND_CODE      3'h7
`define RST_RC_CALIB_ENABLE  1'h1
`define RST_RESOLUTION       2'h0

// Crystal periods in one RC oscillator period
`define RC_DIVIDE            750
// RC periods spent in the automatic initial calibration
`define CALIB_RC_PERIODS     8

`endif

//--- rtl/wake_on_radio_timer_control.v
// Wake-on-radio sleep timer control: register file, RC clock derivation,
// automatic RC calibration and the first and second timeout counters.
// Assumes a single crystal clock domain and a simple synchronous register
// port; all inputs are synchronous to clk.
`timescale 1ns/1ps
`include "wor_timer_defines.vh"

// Operation
// - Clearing bit 7 powers RC, starts calibration.
// - RC period is 750 crystal periods.
// - Code 6:4 picks 4..48 RC periods.
// - Second-timeout code resets to 7, read-write.
// - Bit 3 enables calibration; resets to one.
// - Resolution 1:0 scales unit by 32^n.
// - Every resolution setting is honoured.
// - First timeout is 750*count*2^(5*res) crystal periods.
// - Count split high/low bytes, reset 0x87/0x6B.
module wake_on_radio_timer_control
#(
   parameter RC_DIVIDE   = `RC_DIVIDE,
   parameter CALIB_TICKS = `CALIB_RC_PERIODS
)
(
   // Clock and reset
   input  wire       clk,
   input  wire       rst_b,
   // Register port
   input  wire [5:0] regAddr,
   input  wire       regWrEn,
   input  wire [7:0] regWrData,
   input  wire       regRdEn,
   output reg  [7:0] regRdData,
   // Timer status and events
   output reg        rcRunning,
   output reg        rcTick,
   output reg        calibBusy,
   output reg        firstTimeout,
   output reg        secondTimeout
);

   // Register storage
   reg  [7:0]  countHigh_reg;      // First-timeout count, high byte
   reg  [7:0]  countLow_reg;       // First-timeout count, low byte
   reg         rcPowerdown_reg;    // RC oscillator power-down
   reg  [2:0]  secondCode_reg;     // Second-timeout code
   reg         calibEnable_reg;    // RC calibration enable
   reg  [1:0]  resolution_reg;     // First-timeout resolution

   // Timer state
   reg  [9:0]  rcDiv_reg;          // Crystal-to-RC divider
   reg  [14:0] prescale_reg;       // RC periods within one count unit
   reg  [15:0] unitCnt_reg;        // Count units elapsed
   reg  [5:0]  secondCnt_reg;      // RC periods since first timeout
   reg         secondArmed_reg;    // Second timeout pending
   reg  [3:0]  calibCnt_reg;       // Calibration progress

   wire [15:0] firstCount;         // Full 16-bit first-timeout count
   wire        writeCtrl;          // Control register write strobe
   wire        rcTickNow;          // RC period boundary this cycle
   wire [14:0] unitLast;           // Last prescale value of one unit
   wire        unitDone;           // One count unit ends this cycle
   wire        firstDone;          // First timeout expires this cycle
   wire        secondDone;         // Second timeout expires this cycle

   // Second-timeout code to RC periods
   function [5:0] second_periods;
      input [2:0] code;
      begin
         case (code)
            3'h0:    second_periods = 6'h04;
            3'h1:    second_periods = 6'h06;
            3'h2:    second_periods = 6'h08;
            3'h3:    second_periods = 6'h0C;
            3'h4:    second_periods = 6'h10;
            3'h5:    second_periods = 6'h18;
            3'h6:    second_periods = 6'h20;
            default: second_periods = 6'h30;
         endcase
      end
   endfunction

   // Resolution to RC periods per unit, minus one
   function [14:0] unit_last;
      input [1:0] res;
      begin
         case (res)
            2'h0:    unit_last = 15'h0000;
            2'h1:    unit_last = 15'h001F;
            2'h2:    unit_last = 15'h03FF;
            default: unit_last = 15'h7FFF;
         endcase
      end
   endfunction

   assign firstCount = {countHigh_reg, countLow_reg};
   assign writeCtrl  = regWrEn && (regAddr == `OFS_WAKE_CONTROL);
   // RC runs only while powered; the divider marks each RC period
   assign rcTickNow  = !rcPowerdown_reg &&
                       (rcDiv_reg == RC_DIVIDE[9:0] - 10'h001);
   // Every resolution setting scales the unit, none is refused
   assign unitLast   = unit_last(resolution_reg);
   assign unitDone   = rcTickNow && (prescale_reg == unitLast);
   // A zero count behaves as one unit so the timer never stalls
   assign firstDone  = unitDone &&
                       (unitCnt_reg + 16'h0001 >= firstCount);
   assign secondDone = rcTickNow && secondArmed_reg &&
                       (secondCnt_reg + 6'h01 ==
                        second_periods(secondCode_reg));

   // Register writes; every field loads its default at reset
   always @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         countHigh_reg   <= `RST_FIRST_COUNT_HIGH;
         countLow_reg    <= `RST_FIRST_COUNT_LOW;
         rcPowerdown_reg <= `RST_RC_POWERDOWN;
         secondCode_reg  <= `RST_SECOND_CODE;
         calibEnable_reg <= `RST_RC_CALIB_ENABLE;
         resolution_reg  <= `RST_RESOLUTION;
      end
      else if (regWrEn)
      begin
         if (regAddr == `OFS_FIRST_COUNT_HIGH)
            countHigh_reg <= regWrData;
         if (regAddr == `OFS_FIRST_COUNT_LOW)
            countLow_reg <= regWrData;
         if (writeCtrl)
         begin
            rcPowerdown_reg <= regWrData[`BIT_RC_POWERDOWN];
            secondCode_reg  <=
               regWrData[`MSB_SECOND_CODE:`LSB_SECOND_CODE];
            calibEnable_reg <= regWrData[`BIT_RC_CALIB_ENABLE];
            resolution_reg  <=
               regWrData[`MSB_RESOLUTION:`LSB_RESOLUTION];
         end
      end
   end

   // Registered read data; unused bit 2 and unmapped offsets read zero
   always @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
         regRdData <= 8'h00;
      else if (regRdEn)
      begin
         case (regAddr)
            `OFS_FIRST_COUNT_HIGH: regRdData <= countHigh_reg;
            `OFS_FIRST_COUNT_LOW:  regRdData <= countLow_reg;
            `OFS_WAKE_CONTROL:     regRdData <= {rcPowerdown_reg,
                                                 secondCode_reg,
                                                 calibEnable_reg,
                                                 1'b0,
                                                 resolution_reg};
            default:               regRdData <= 8'h00;
         endcase
      end
   end

   // RC clock divider; held in reset while powered down to save power
   always @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
         rcDiv_reg <= 10'h000;
      else if (rcPowerdown_reg || rcTickNow)
         rcDiv_reg <= 10'h000;
      else
         rcDiv_reg <= rcDiv_reg + 10'h001;
   end

   // Automatic initial calibration on a 1-to-0 power-down write
   always @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
         calibCnt_reg <= 4'h0;
      else if (writeCtrl && rcPowerdown_reg &&
               !regWrData[`BIT_RC_POWERDOWN] &&
               regWrData[`BIT_RC_CALIB_ENABLE])
         calibCnt_reg <= CALIB_TICKS[3:0];
      else if (rcPowerdown_reg || !calibEnable_reg)
         calibCnt_reg <= 4'h0;
      else if (rcTickNow && (calibCnt_reg != 4'h0))
         calibCnt_reg <= calibCnt_reg - 4'h1;
   end

   // First timeout: unit prescaler and unit counter, restarting at expiry
   always @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         prescale_reg <= 15'h0000;
         unitCnt_reg  <= 16'h0000;
      end
      else if (rcPowerdown_reg)
      begin
         // A powered-down oscillator restarts the timeout from zero
         prescale_reg <= 15'h0000;
         unitCnt_reg  <= 16'h0000;
      end
      else if (rcTickNow)
      begin
         // Shrinking the resolution mid-unit must not strand the count
         if (prescale_reg >= unitLast)
         begin
            prescale_reg <= 15'h0000;
            if (firstDone)
               unitCnt_reg <= 16'h0000;
            else
               unitCnt_reg <= unitCnt_reg + 16'h0001;
         end
         else
            prescale_reg <= prescale_reg + 15'h0001;
      end
   end

   // Second timeout: armed at each first expiry, counts RC periods
   always @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         secondCnt_reg   <= 6'h00;
         secondArmed_reg <= 1'b0;
      end
      else if (rcPowerdown_reg)
      begin
         secondCnt_reg   <= 6'h00;
         secondArmed_reg <= 1'b0;
      end
      else if (firstDone)
      begin
         // A new first timeout restarts any second timeout in flight
         secondCnt_reg   <= 6'h00;
         secondArmed_reg <= 1'b1;
      end
      else if (secondDone)
      begin
         secondCnt_reg   <= 6'h00;
         secondArmed_reg <= 1'b0;
      end
      else if (rcTickNow && secondArmed_reg)
         secondCnt_reg <= secondCnt_reg + 6'h01;
   end

   // Status and event outputs, all from flip-flops
   always @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         rcRunning     <= 1'b0;
         rcTick        <= 1'b0;
         calibBusy     <= 1'b0;
         firstTimeout  <= 1'b0;
         secondTimeout <= 1'b0;
      end
      else
      begin
         rcRunning     <= !rcPowerdown_reg;
         rcTick        <= rcTickNow;
         calibBusy     <= (calibCnt_reg != 4'h0);
         firstTimeout  <= firstDone;
         secondTimeout <= secondDone;
      end
   end

endmodule // wake_on_radio_timer_control

//--- testbench/wor_timer_properties.sv
// Port checker for the wake-on-radio timer control block.
// Assumes one clock domain and register strobes one cycle long.
`timescale 1ns/1ps
`include "wor_timer_defines.vh"
module wor_timer_properties
#(
   parameter RC_DIVIDE   = 750,
   parameter CALIB_TICKS = 8
)
(
   // Clock, reset and register port
   input wire       clk,
   input wire       rst_b,
   input wire [5:0] regAddr,
   input wire       regWrEn,
   input wire [7:0] regWrData,
   input wire       regRdEn,
   input wire [7:0] regRdData,
   // Status and events
   input wire       rcRunning,
   input wire       rcTick,
   input wire       calibBusy,
   input wire       firstTimeout,
   input wire       secondTimeout
);
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_b);
   integer gap;   // Cycles since the last RC tick
   reg     seen;  // A tick was seen since power-up
   // Tick spacing tracker; restarts while powered down so the first
   // tick after power-up is not judged against a stale gap
   always @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         gap  <= 0;
         seen <= 1'b0;
      end
      else
      begin
         gap  <= rcTick ? 1 : gap + 1;
         seen <= rcRunning & (seen | rcTick);
      end
   end
   // A write to the control register
   sequence wrCtl;
      regWrEn && regAddr == `OFS_WAKE_CONTROL;
   endsequence
   tick_spacing_a: assert property (rcTick && seen |-> gap == RC_DIVIDE)
      else $error("RC tick spacing wrong");
   tick_needs_power_a: assert property (rcTick |-> rcRunning)
      else $error("RC tick while powered down");
   first_on_tick_a: assert property (firstTimeout |-> rcTick)
      else $error("First timeout off the RC tick");
   second_on_tick_a: assert property (secondTimeout |-> rcTick)
      else $error("Second timeout off the RC tick");
   power_up_a: assert property (wrCtl ##0 !regWrData[7] |=> ##1 rcRunning)
      else $error("RC not running after power-up write");
   power_down_a: assert property (wrCtl ##0 regWrData[7]
      |=> ##1 !rcRunning ##1 !rcTick [*4])
      else $error("RC still running after power-down write");
   calib_start_a: assert property ($rose(calibBusy) |-> $rose(rcRunning))
      else $error("Calibration started without power-up");
   ctl_readback_a: assert property (wrCtl ##1 !regWrEn ##1 (regRdEn &&
      !regWrEn && regAddr == `OFS_WAKE_CONTROL)
      |=> regRdData == ($past(regWrData, 3) & 8'hFB))
      else $error("Control readback differs from write");
endmodule // wor_timer_properties

bind wake_on_radio_timer_control wor_timer_properties
   #(.RC_DIVIDE(RC_DIVIDE), .CALIB_TICKS(CALIB_TICKS)) chk_u
   (.clk(clk), .rst_b(rst_b), .regAddr(regAddr), .regWrEn(regWrEn),
    .regWrData(regWrData), .regRdEn(regRdEn), .regRdData(regRdData),
    .rcRunning(rcRunning), .rcTick(rcTick), .calibBusy(calibBusy),
    .firstTimeout(firstTimeout), .secondTimeout(secondTimeout));

//--- testbench/tb_wake_on_radio_timer_control.sv
// Self-checking bench for the wake-on-radio timer control block.
// Assumes a shortened RC divider; inputs change on the falling edge.
`timescale 1ns/1ps
`include "wor_timer_defines.vh"
module tb_wake_on_radio_timer_control;
   localparam D = 4;  // Short RC divide keeps long timeouts cheap
   reg        clk = 1'b0;
   reg        rst_b = 1'b0;
   reg  [5:0] regAddr = 6'h00;
   reg        regWrEn = 1'b0;
   reg  [7:0] regWrData = 8'h00;
   reg        regRdEn = 1'b0;
   wire [7:0] regRdData;
   wire       rcRunning, rcTick, calibBusy, firstTimeout, secondTimeout;
   int        n_mismatch = 0, samples_checked = 0, cyc = 0, n, i;
   int        ticksTab [8] = '{4, 6, 8, 12, 16, 24, 32, 48};
   wake_on_radio_timer_control #(.RC_DIVIDE(D), .CALIB_TICKS(2)) dut_u
   (.clk(clk), .rst_b(rst_b), .regAddr(regAddr), .regWrEn(regWrEn),
    .regWrData(regWrData), .regRdEn(regRdEn), .regRdData(regRdData),
    .rcRunning(rcRunning), .rcTick(rcTick), .calibBusy(calibBusy),
    .firstTimeout(firstTimeout), .secondTimeout(secondTimeout));
   always #20 clk = ~clk;
   // Hang guard; whole run should need about 20000 cycles
   always @(posedge clk)
   begin
      cyc++;
      if (cyc == 40000)
      begin
         n_mismatch++;
         test_done();
      end
   end
   task chkv(input logic [7:0] g, input logic [7:0] e);
      samples_checked++;
      if (g !== e)
      begin
         n_mismatch++;
         $display("ERROR t=%0t value %h expected %h", $time, g, e);
      end
   endtask
   task chkn(input logic [31:0] g, input logic [31:0] e);
      samples_checked++;
      if (g !== e)
      begin
         n_mismatch++;
         $display("ERROR t=%0t count %0d expected %0d", $time, g, e);
      end
   endtask
   task wr(input logic [5:0] a, input logic [7:0] d);
      regAddr = a;
      regWrData = d;
      regWrEn = 1'b1;
      @(negedge clk);
      regWrEn = 1'b0;
      // Idle cycle so a following write never re-raises the strobe at once
      @(negedge clk);
   endtask
   task rd(input logic [5:0] a, input logic [7:0] e);
      regAddr = a;
      regRdEn = 1'b1;
      @(negedge clk);
      regRdEn = 1'b0;
      chkv(regRdData, e);
      // Read data stands; idle cycle keeps strobes apart
      @(negedge clk);
   endtask
   // Cycles until the chosen event pulse, bounded
   task waitp(input int s, output int c);
      c = 0;
      do
      begin
         @(negedge clk);
         c++;
      end
      while ((s ? secondTimeout : firstTimeout) !== 1'b1 && c < 9000);
   endtask
   task t_regs;
      rd(`OFS_FIRST_COUNT_HIGH, 8'h87);
      rd(`OFS_FIRST_COUNT_LOW, 8'h6B);
      rd(`OFS_WAKE_CONTROL, 8'hF8);
      rd(6'h21, 8'h00);
      wr(`OFS_WAKE_CONTROL, 8'hF4);
      rd(`OFS_WAKE_CONTROL, 8'hF0);
   endtask
   task t_power;
      wr(`OFS_FIRST_COUNT_HIGH, 8'h00);
      wr(`OFS_FIRST_COUNT_LOW, 8'h32);
      wr(`OFS_WAKE_CONTROL, 8'h08);
      repeat (2) @(negedge clk);
      chkv({rcRunning, calibBusy}, 8'h03);
      repeat (4 * D) @(negedge clk);
      chkv({7'h00, calibBusy}, 8'h00);
      waitp(0, n);
      waitp(0, n);
      chkn(n, 50 * D);
   endtask
   task t_codes;
      for (i = 0; i < 8; i++)
      begin
         // Periodic use keeps the finest resolution
         wr(`OFS_WAKE_CONTROL, {1'b0, i[2:0], 4'h0});
         waitp(0, n);
         waitp(1, n);
         chkn(n, ticksTab[i] * D);
      end
   endtask
   task t_res;
      wr(`OFS_FIRST_COUNT_LOW, 8'h01);
      rd(`OFS_FIRST_COUNT_HIGH, 8'h00);
      rd(`OFS_FIRST_COUNT_LOW, 8'h01);
      for (i = 0; i < 3; i++)
      begin
         wr(`OFS_WAKE_CONTROL, {6'h00, i[1:0]});
         waitp(0, n);
         waitp(0, n);
         chkn(n, D << (5 * i));
      end
      // Coarsest unit is far beyond the wait limit: no expiry may come
      wr(`OFS_WAKE_CONTROL, 8'h03);
      rd(`OFS_WAKE_CONTROL, 8'h03);
      waitp(0, n);
      chkn(n, 9000);
   endtask
   task t_down;
      wr(`OFS_WAKE_CONTROL, 8'hF8);
      repeat (2) @(negedge clk);
      n = 0;
      repeat (20)
      begin
         @(negedge clk);
         n += (rcTick | rcRunning);
      end
      chkn(n, 0);
      // Power-up with calibration disabled must not calibrate
      wr(`OFS_WAKE_CONTROL, 8'h00);
      repeat (2) @(negedge clk);
      chkv({rcRunning, calibBusy}, 8'h02);
   endtask
   task test_done;
      $display("Mismatches %0d, checks %0d", n_mismatch, samples_checked);
      if (n_mismatch == 0 && samples_checked > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   initial
   begin
      repeat (12) @(negedge clk);
      rst_b = 1'b1;
      @(negedge clk);
      t_regs();
      t_power();
      t_codes();
      t_res();
      t_down();
      test_done();
   end
endmodule // tb_wake_on_radio_timer_control
